/* File: verilog/pmode_regs.vh */
// Constants for the power-mode sequencer: state codes and settling counts
`ifndef PMODE_REGS_VH
`define PMODE_REGS_VH

// Mode state encodings (3 bits)
`define PM_MODE_W      3
`define PM_RESET       3'h0
`define PM_ACTIVE      3'h1
`define PM_SLEEP       3'h2
`define PM_SUBACT      3'h3
`define PM_SUBSLEEP    3'h4
`define PM_STANDBY     3'h5
`define PM_WAKE        3'h6

// Settling-time select width and counter geometry
`define PM_STS_W       3
`define PM_CNT_W       24
// Settling base count in mclk cycles; the select shifts it left
`define PM_SETTLE_UNIT 24'h002000

`endif

/* File: verilog/settle_counter.v */
// Oscillator settling counter used on wake-up from standby
`default_nettype none
`include "pmode_regs.vh"

module settle_counter #(
    parameter CNT_W       = `PM_CNT_W,       // Counter width
    parameter SETTLE_UNIT = `PM_SETTLE_UNIT  // Base settling count in cycles
) (
    input  wire                 mclk,        // System clock
    input  wire                 srst,        // Synchronous reset, active high
    input  wire                 load,        // Start a new settling wait
    input  wire [`PM_STS_W-1:0] sel,         // Settling-time select
    output reg                  done_ff      // One-cycle pulse when wait ends
);

    // Wait length: base count doubled per select step, never below one cycle
    function [CNT_W-1:0] settle_len;
        input [`PM_STS_W-1:0] s;
        reg   [CNT_W-1:0]     v;
        begin
            v = SETTLE_UNIT[CNT_W-1:0] << s;
            settle_len = (v == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : v;
        end
    endfunction

    reg [CNT_W-1:0] cnt_ff;   // Remaining cycles
    reg             busy_ff;  // Wait in progress

    // Count down and fire once at the end
    always @(posedge mclk) begin
        if (srst) begin
            cnt_ff  <= {CNT_W{1'b0}};
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (load) begin
            // A reload restarts the wait from full length
            cnt_ff  <= settle_len(sel);
            busy_ff <= 1'b1;
            done_ff <= 1'b0;
        end else if (busy_ff) begin
            cnt_ff  <= cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
            busy_ff <= (cnt_ff != {{(CNT_W-1){1'b0}}, 1'b1});
            done_ff <= (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
        end else begin
            done_ff <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: verilog/power_mode_transition_ctrl.v */
// Power-mode sequencer: halt, wake-up and direct transitions
`default_nettype none
`include "pmode_regs.vh"

// Functional notes
// R1: Halt in execution state enters halted state
// R2: Accepted interrupt returns halted state to execution
// R3: Direct switch between active and subclock execution
// R4: Direct same-mode transition reapplies operating frequency
// R5: External reset low forces reset state
// R6: Halt target from standby and sub-halt selects
// R7: Wake-up goes active or subclock per low-speed (code: wake from standby always goes to active)
// R8: Direct, sub-halt 0, low-speed 0 gives active
// R9: Direct with low-speed 1 gives subclock
// R10: Sub-halt transition resets timer, serial, converter
// R11: Software rewrites reset peripherals after return
// R12: First timer counts in low power if timekeeping
// R13: Third timer holds, or counts subclock if sys
// R14: Watchdog holds unless clocked by internal oscillator
// R15: Third timer, watchdog, two-wire registers accessible subclock
// R16: No wake while masked or source disabled
// R17: Standby wake waits settling time before exceptions
// R18: Direct request with interrupt disabled enters sleep
// R19: Mode state register with gate, reset outputs
module power_mode_transition_ctrl #(
    parameter CNT_W       = `PM_CNT_W,       // Settling counter width
    parameter SETTLE_UNIT = `PM_SETTLE_UNIT  // Base settling count in cycles
) (
    input  wire                  mclk,                  // 20 MHz system clock
    input  wire                  srst,                  // Synchronous reset
    input  wire                  ext_reset_n,           // Reset pin, async, low
    input  wire                  halt_exec,             // CPU executes halt
    input  wire                  direct_transition_sel, // Direct-transition bit
    input  wire                  standby_sel,           // Standby select bit
    input  wire                  sub_halt_sel,          // Sub-halt select bit
    input  wire                  low_speed_sel,         // Low-speed select bit
    input  wire [`PM_STS_W-1:0]  settling_time_sel,     // Settling-time select
    input  wire                  dt_irq_en,             // Direct-transition irq on
    input  wire                  irq_req,               // Interrupt request
    input  wire                  irq_src_en,            // Source enabled
    input  wire                  cpu_irq_mask,          // Global mask set
    input  wire                  timekeep_sel,          // First timer time-base
    input  wire                  timer3_sys_clk,        // Third timer on sys clk
    input  wire                  wdt_osc_clk,           // Watchdog on int osc
    output reg [`PM_MODE_W-1:0]  mode_ff,               // Current mode
    output reg                   sys_clk_en_ff,         // System oscillator on
    output reg                   sub_clk_en_ff,         // Subclock oscillator on
    output reg                   cpu_run_ff,            // CPU executes
    output reg                   periph_rst_ff,         // Timer2/serial/conv reset
    output reg                   timer1_run_ff,         // First timer counts
    output reg                   timer3_run_ff,         // Third timer counts
    output reg                   timer3_sub_ff,         // Third timer on subclock
    output reg                   wdt_run_ff,            // Watchdog counts
    output reg                   reg_access_ff,         // Low-power reg access
    output reg                   exc_start_ff,          // Start irq exception
    output reg                   dt_exc_ff              // Direct-transition exc
);

    // Reset pin synchroniser; first stage feeds only the second
    // Clearing to 0 makes the pin read as asserted for two edges after srst,
    // so the sequencer always passes through reset before running code
    reg rst_pin_s1_ff;
    reg rst_pin_s2_ff;

    always @(posedge mclk) begin
        if (srst) begin
            rst_pin_s1_ff <= 1'b0;
            rst_pin_s2_ff <= 1'b0;
        end else begin
            rst_pin_s1_ff <= ext_reset_n;
            rst_pin_s2_ff <= rst_pin_s1_ff;
        end
    end

    // A pin reset mid-wait leaves the counter running; its late pulse is
    // ignored outside the settling state, and the next wake reloads it
    wire settle_done;  // Settling wait finished
    reg  settle_load;  // Start settling wait

    settle_counter #(
        .CNT_W       (CNT_W),
        .SETTLE_UNIT (SETTLE_UNIT)
    ) u_settle (
        .mclk    (mclk),
        .srst    (srst),
        .load    (settle_load),
        .sel     (settling_time_sel),
        .done_ff (settle_done)
    );

    // Mode classification, applied to the next mode only
    // Low-power set is where the system oscillator is stopped
    function is_exec;
        input [`PM_MODE_W-1:0] m;
        begin
            is_exec = (m == `PM_ACTIVE) || (m == `PM_SUBACT);
        end
    endfunction

    function is_lowpow;
        input [`PM_MODE_W-1:0] m;
        begin
            is_lowpow = (m == `PM_SUBACT) || (m == `PM_SUBSLEEP) || (m == `PM_STANDBY);
        end
    endfunction

    // Wake is accepted only with mask clear and source enabled
    // A refused request is left pending at its source, not dropped here
    wire wake_ok = irq_req && irq_src_en && !cpu_irq_mask;  // [R16]

    reg [`PM_MODE_W-1:0] nxt_mode;     // Next mode
    reg                  nxt_exc;      // Exception start
    reg                  nxt_dt_exc;   // Direct-transition exception
    reg                  nxt_prst;     // Sub-halt transition reset pulse

    // Transition decision
    always @* begin
        nxt_mode    = mode_ff;
        nxt_exc     = 1'b0;
        nxt_dt_exc  = 1'b0;
        nxt_prst    = 1'b0;
        settle_load = 1'b0;
        // Pin reset overrides every request, halted or not
        if (!rst_pin_s2_ff) begin
            nxt_mode = `PM_RESET;                                   // [R5]
        end else begin
            case (mode_ff)
                `PM_RESET: begin
                    // Leave reset one edge after the synchronised pin reads high
                    nxt_mode = `PM_ACTIVE;
                end
                `PM_ACTIVE, `PM_SUBACT: begin
                    if (halt_exec) begin
                        nxt_prst = sub_halt_sel;                    // [R10]
                        if (direct_transition_sel && dt_irq_en) begin
                            // Same-mode target just reapplies the clock setting
                            nxt_mode   = low_speed_sel ? `PM_SUBACT
                                                       : `PM_ACTIVE; // [R3] [R4] [R8] [R9]
                            nxt_dt_exc = 1'b1;
                        end else if (direct_transition_sel) begin
                            // Direct request with its interrupt off falls to halt
                            nxt_mode = sub_halt_sel ? `PM_SUBSLEEP
                                                    : `PM_SLEEP;    // [R18]
                        end else if (standby_sel) begin
                            nxt_mode = `PM_STANDBY;                 // [R1] [R6]
                        end else begin
                            nxt_mode = sub_halt_sel ? `PM_SUBSLEEP
                                                    : `PM_SLEEP;    // [R1] [R6]
                        end
                    end
                end
                `PM_SLEEP, `PM_SUBSLEEP: begin
                    if (wake_ok) begin
                        nxt_mode = low_speed_sel ? `PM_SUBACT
                                                 : `PM_ACTIVE;      // [R2] [R7]
                        nxt_exc  = 1'b1;
                    end
                end
                `PM_STANDBY: begin
                    // Restart the oscillator and wait before running code
                    if (wake_ok) begin
                        nxt_mode    = `PM_WAKE;                     // [R17]
                        settle_load = 1'b1;
                    end
                end
                `PM_WAKE: begin
                    if (settle_done) begin
                        nxt_mode = `PM_ACTIVE;                      // [R2] [R7] [R17]
                        nxt_exc  = 1'b1;
                    end
                end
                default: begin
                    // Unused code falls back to reset
                    nxt_mode = `PM_RESET;
                end
            endcase
        end
    end

    // State and per-mode controls, all registered from the next mode
    // Decoding from the next mode lets controls switch on the same edge as
    // mode_ff; decoding from mode_ff would lag them by a cycle
    always @(posedge mclk) begin
        if (srst) begin
            mode_ff       <= `PM_RESET;
            sys_clk_en_ff <= 1'b1;
            sub_clk_en_ff <= 1'b1;
            cpu_run_ff    <= 1'b0;
            periph_rst_ff <= 1'b1;
            timer1_run_ff <= 1'b0;
            timer3_run_ff <= 1'b0;
            timer3_sub_ff <= 1'b0;
            wdt_run_ff    <= 1'b0;
            reg_access_ff <= 1'b0;
            exc_start_ff  <= 1'b0;
            dt_exc_ff     <= 1'b0;
        end else begin
            mode_ff       <= nxt_mode;                              // [R19]
            // System oscillator runs in active, sleep, reset and settling
            sys_clk_en_ff <= (nxt_mode == `PM_ACTIVE) || (nxt_mode == `PM_SLEEP) ||
                             (nxt_mode == `PM_RESET) || (nxt_mode == `PM_WAKE); // [R19]
            sub_clk_en_ff <= 1'b1;
            cpu_run_ff    <= is_exec(nxt_mode);
            // Held in reset in low-power modes and on sub-halt transitions
            periph_rst_ff <= (nxt_mode == `PM_RESET) || is_lowpow(nxt_mode) ||
                             nxt_prst;                              // [R10] [R19]
            timer1_run_ff <= is_lowpow(nxt_mode) ? timekeep_sel
                                                 : (nxt_mode != `PM_RESET); // [R12]
            // In low-power modes the third timer counts only when moved onto the subclock
            timer3_run_ff <= is_lowpow(nxt_mode) ? timer3_sys_clk
                                                 : (nxt_mode != `PM_RESET); // [R13]
            timer3_sub_ff <= is_lowpow(nxt_mode) && timer3_sys_clk; // [R13]
            wdt_run_ff    <= is_lowpow(nxt_mode) ? wdt_osc_clk
                                                 : (nxt_mode != `PM_RESET); // [R14]
            // Registers stay reachable whenever the CPU executes
            reg_access_ff <= is_exec(nxt_mode);                     // [R15]
            exc_start_ff  <= nxt_exc;                               // [R2]
            dt_exc_ff     <= nxt_dt_exc;                            // [R3]
        end
    end

endmodule
`default_nettype wire

/* File: verification/irq_src_model.sv */
// Interrupt source model facing the sequencer's wake-up input
`default_nettype none
module irq_src_model (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic raise,        // One-cycle request from the test
    input  wire logic exc_start_ff, // Exception start from the sequencer
    output var  logic irq_req       // Level request, like a real source
);
    timeunit 1ns;
    timeprecision 1ns;
    // Held until handling starts, so a masked request stays pending
    always @(posedge mclk) begin
        if (srst) begin
            irq_req <= 1'h0;
        end else if (exc_start_ff) begin
            irq_req <= 1'h0;
        end else if (raise) begin
            irq_req <= 1'h1;
        end
    end
endmodule
`default_nettype wire

/* File: verification/pm_chk_asserts.sv */
// Concurrent checks on the power-mode sequencer ports
`default_nettype none
`include "pmode_regs.vh"
module pm_chk (
    input wire logic                  mclk,
    input wire logic                  srst,
    input wire logic                  ext_reset_n,
    input wire logic                  halt_exec,
    input wire logic                  direct_transition_sel,
    input wire logic                  standby_sel,
    input wire logic                  sub_halt_sel,
    input wire logic                  low_speed_sel,
    input wire logic                  dt_irq_en,
    input wire logic                  irq_req,
    input wire logic                  irq_src_en,
    input wire logic                  cpu_irq_mask,
    input wire logic                  timekeep_sel,
    input wire logic                  timer3_sys_clk,
    input wire logic                  wdt_osc_clk,
    input wire logic                  sys_clk_en_ff,
    input wire logic                  sub_clk_en_ff,
    input wire logic                  cpu_run_ff,
    input wire logic                  periph_rst_ff,
    input wire logic                  timer1_run_ff,
    input wire logic                  timer3_run_ff,
    input wire logic                  timer3_sub_ff,
    input wire logic                  wdt_run_ff,
    input wire logic                  reg_access_ff,
    input wire logic                  exc_start_ff,
    input wire logic                  dt_exc_ff,
    input wire logic [`PM_MODE_W-1:0] mode_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Halt counts only in an execution mode
    wire logic go = halt_exec && (mode_ff == `PM_ACTIVE || mode_ff == `PM_SUBACT);
    wire logic dir = direct_transition_sel && dt_irq_en;
    // Pin low excluded: reset overrides any wake
    wire logic wake = irq_req && irq_src_en && !cpu_irq_mask && ext_reset_n;
    wire logic hlt = mode_ff == `PM_SLEEP || mode_ff == `PM_SUBSLEEP;
    wire logic lowp = mode_ff inside {`PM_SUBACT, `PM_SUBSLEEP, `PM_STANDBY};
    // Expected halt target from the select bits
    wire logic [`PM_MODE_W-1:0] tgt = dir ? (low_speed_sel ? `PM_SUBACT : `PM_ACTIVE) :
        (standby_sel && !direct_transition_sel) ? `PM_STANDBY :
        sub_halt_sel ? `PM_SUBSLEEP : `PM_SLEEP;
    AST_HALT_TGT: assert property (go |=> mode_ff == $past(tgt))
        else $error("halt target mode wrong");
    AST_DT_PULSE: assert property (go && dir |=> dt_exc_ff ##1 !dt_exc_ff)
        else $error("direct transition pulse wrong");
    AST_WAKE: assert property (wake && hlt |=> exc_start_ff &&
        mode_ff == ($past(low_speed_sel) ? `PM_SUBACT : `PM_ACTIVE))
        else $error("wake-up mode wrong");
    AST_STBY: assert property (wake && mode_ff == `PM_STANDBY |=>
        mode_ff == `PM_WAKE && sys_clk_en_ff ##[1:600] mode_ff == `PM_ACTIVE && exc_start_ff)
        else $error("standby wake sequence wrong");
    AST_SETTLE: assert property (mode_ff == `PM_WAKE && ext_reset_n |=>
        mode_ff inside {`PM_WAKE, `PM_ACTIVE})
        else $error("settling left to wrong mode");
    AST_HOLD: assert property ((hlt || mode_ff == `PM_STANDBY) && !wake && ext_reset_n
        |=> $stable(mode_ff))
        else $error("halted mode left without wake");
    AST_PIN: assert property (!ext_reset_n [*3] |=> mode_ff == `PM_RESET)
        else $error("pin reset not taken");
    AST_CTRL: assert property (cpu_run_ff == (mode_ff inside {`PM_ACTIVE, `PM_SUBACT})
        && reg_access_ff == cpu_run_ff && sys_clk_en_ff ==
        (mode_ff inside {`PM_RESET, `PM_ACTIVE, `PM_SLEEP, `PM_WAKE}) && sub_clk_en_ff)
        else $error("mode controls wrong");
    AST_LOWP: assert property (lowp |-> periph_rst_ff &&
        timer1_run_ff == $past(timekeep_sel) && timer3_sub_ff == $past(timer3_sys_clk)
        && wdt_run_ff == $past(wdt_osc_clk) && timer3_run_ff == $past(timer3_sys_clk))
        else $error("low-power peripheral controls wrong");
    cover property (go && dir);
    cover property (mode_ff == `PM_WAKE ##1 mode_ff == `PM_ACTIVE);
    cover property (wake && mode_ff == `PM_SUBSLEEP);
endmodule
bind power_mode_transition_ctrl pm_chk u_pm_chk (.mclk, .srst, .ext_reset_n, .halt_exec,
    .direct_transition_sel, .standby_sel, .sub_halt_sel, .low_speed_sel, .dt_irq_en,
    .irq_req, .irq_src_en, .cpu_irq_mask, .timekeep_sel, .timer3_sys_clk, .wdt_osc_clk,
    .sys_clk_en_ff, .sub_clk_en_ff, .cpu_run_ff, .periph_rst_ff, .timer1_run_ff,
    .timer3_run_ff, .timer3_sub_ff,
    .wdt_run_ff, .reg_access_ff, .exc_start_ff, .dt_exc_ff, .mode_ff);
`default_nettype wire

/* File: verification/power_mode_transition_ctrl_tb_top.sv */
// Self-checking bench for the power-mode sequencer
`default_nettype none
`include "pmode_regs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module power_mode_transition_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, srst = 1'h1, ext_reset_n = 1'h1, halt_exec = 1'h0, raise = 1'h0;
    logic direct_transition_sel = 1'h0, standby_sel = 1'h0, sub_halt_sel = 1'h0;
    logic low_speed_sel = 1'h0, dt_irq_en = 1'h1, irq_src_en = 1'h1, cpu_irq_mask = 1'h0;
    logic timekeep_sel = 1'h0, timer3_sys_clk = 1'h0, wdt_osc_clk = 1'h0, irq_req;
    logic [2:0] settling_time_sel = 3'h1; // Eight-cycle wait with the short unit
    logic [`PM_MODE_W-1:0] mode_ff, eh, ew;
    logic sys_clk_en_ff, cpu_run_ff, periph_rst_ff, timer1_run_ff, timer3_sub_ff;
    logic wdt_run_ff, reg_access_ff, exc_start_ff, dt_exc_ff, sub_clk_en_ff, timer3_run_ff;
    logic [4:0] r; // {irq enable, direct, standby, sub-halt, low-speed}
    logic [4:0] rows [9] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h18, 5'h1f, 5'h0a, 5'h08};
    int fails = 0, check_count = 0, i, k;
    always #25 mclk = ~mclk;
    power_mode_transition_ctrl #(.SETTLE_UNIT(24'h000004)) u_power_mode_transition_ctrl (
        .mclk, .srst, .ext_reset_n, .halt_exec, .direct_transition_sel, .standby_sel,
        .sub_halt_sel, .low_speed_sel, .settling_time_sel, .dt_irq_en, .irq_req, .irq_src_en,
        .cpu_irq_mask, .timekeep_sel, .timer3_sys_clk, .wdt_osc_clk, .mode_ff, .sys_clk_en_ff,
        .sub_clk_en_ff, .cpu_run_ff, .periph_rst_ff, .timer1_run_ff, .timer3_run_ff,
        .timer3_sub_ff, .wdt_run_ff, .reg_access_ff, .exc_start_ff, .dt_exc_ff);
    irq_src_model u_irq_src_model (.mclk, .srst, .raise, .exc_start_ff, .irq_req);
    // One halt pulse with selects and clock sources set beside it
    task automatic halt_with(input logic [4:0] sel, input logic [2:0] src);
        @(posedge mclk);
        {dt_irq_en, direct_transition_sel, standby_sel, sub_halt_sel, low_speed_sel} <= sel;
        {timekeep_sel, timer3_sys_clk, wdt_osc_clk} <= src;
        halt_exec <= 1'h1;
        @(posedge mclk);
        halt_exec <= 1'h0;
        #1;
    endtask
    // Raise a request and wait, bounded, for exception start
    task automatic wake;
        @(posedge mclk);
        raise <= 1'h1;
        @(posedge mclk);
        raise <= 1'h0;
        #1;
        for (k = 0; k < 300 && exc_start_ff !== 1'h1; k++) begin
            @(posedge mclk);
            #1;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        repeat (6) @(posedge mclk);
        #1 `CHK(mode_ff, `PM_ACTIVE)
        for (i = 0; i < 9; i++) begin
            r = rows[i];
            eh = r[3] ? (r[4] ? (r[0] ? 3'h3 : 3'h1) : (r[1] ? 3'h4 : 3'h2)) :
                r[2] ? 3'h5 : (r[1] ? 3'h4 : 3'h2);
            ew = (eh == 3'h5 || !r[0]) ? 3'h1 : 3'h3;
            halt_with(r, i[2:0]);
            `CHK(mode_ff, eh)
            `CHK(dt_exc_ff, r[4] & r[3])
            `CHK(periph_rst_ff, eh >= 3'h3)
            `CHK(cpu_run_ff, eh == 3'h1 || eh == 3'h3)
            `CHK(reg_access_ff, eh == 3'h1 || eh == 3'h3)
            `CHK(sub_clk_en_ff, 1'h1)
            if (eh >= 3'h3) begin
                `CHK(timer1_run_ff, i[2])
                `CHK(timer3_sub_ff, i[1])
                `CHK(timer3_run_ff, i[1])
                `CHK(wdt_run_ff, i[0])
            end else begin
                `CHK(timer1_run_ff, 1'h1)
                `CHK(timer3_sub_ff, 1'h0)
                `CHK(timer3_run_ff, 1'h1)
                `CHK(wdt_run_ff, 1'h1)
            end
            if (eh != 3'h1 && eh != 3'h3) begin
                wake();
                `CHK(mode_ff, ew)
                `CHK(exc_start_ff, 1'h1)
                `CHK(periph_rst_ff, ew == 3'h3)
                if (eh == 3'h5) `CHK(k >= 9 && k <= 11, 1'h1)
            end
            if (eh == 3'h3 || (eh != 3'h1 && ew == 3'h3)) begin
                halt_with(5'h18, 3'h0);
                `CHK(mode_ff, `PM_ACTIVE)
            end
            $display("row %0d done", i);
        end
        halt_with(5'h10, 3'h0);
        @(posedge mclk) cpu_irq_mask <= 1'h1;
        wake();
        `CHK(mode_ff, `PM_SLEEP)
        @(posedge mclk) cpu_irq_mask <= 1'h0;
        irq_src_en <= 1'h0;
        repeat (4) @(posedge mclk);
        #1 `CHK(mode_ff, `PM_SLEEP)
        // Pending request wakes once its source is enabled again
        @(posedge mclk) irq_src_en <= 1'h1;
        @(posedge mclk);
        #1 `CHK(mode_ff, `PM_ACTIVE)
        `CHK(exc_start_ff, 1'h1)
        $display("masked wake done");
        // Shortest settling select: base count only
        @(posedge mclk) settling_time_sel <= 3'h0;
        halt_with(5'h14, 3'h0);
        `CHK(mode_ff, `PM_STANDBY)
        wake();
        `CHK(mode_ff, `PM_ACTIVE)
        `CHK(k >= 5 && k <= 7, 1'h1)
        $display("short settle done");
        halt_with(5'h10, 3'h0);
        @(posedge mclk) ext_reset_n <= 1'h0;
        repeat (4) @(posedge mclk);
        #1 `CHK(mode_ff, `PM_RESET)
        @(posedge mclk) ext_reset_n <= 1'h1;
        repeat (5) @(posedge mclk);
        #1 `CHK(mode_ff, `PM_ACTIVE)
        $display("pin reset done");
        finish_test();
    end
    // Hang guard, several times the expected run
    initial begin
        #300000;
        fails++;
        finish_test();
    end
endmodule
`default_nettype wire
